/* File: design/rtcr_ctrl_regs.v */
// Control and status register bank of a real-time clock (addresses 00h-02h).
// Assumes a same-clock register port from the serial interface, event
// pulses from the tick, watchdog and alarm logic on clk_in, and battery
// switch-over and low-battery levels from the analog supply monitor.
//
// Overview of operation
// RQ1: Control registers occupy addresses 00h through 04h; this bank decodes only 00h-02h, and 03h and 04h read zero here.
// RQ2: Unused bits always read back as zero.
// RQ3: Bit 7 selects normal or external-clock test.
// RQ4: Bit 6 set disables temperature compensation.
// RQ5: Halt bit stops clock, clears divider chain.
// RQ6: Hundredths-off stops counter, forces 06h to zero.
// RQ7: Bypass enable resets high; software clears it.
// RQ8: Bit 2 selects 12-hour or 24-hour format.
// RQ9: Enabled minute/second tick sets tick flag.
// RQ10: Watchdog flag set on expiry; writes cannot clear.
// RQ11: Alarm trigger sets alarm flag; software clears.
// RQ12: Alarm interrupt raised when flag and enable set.
// RQ13: Power management field bits 7-5, reset ones.
// RQ14: Switch-over timestamp captured only when enabled.
// RQ15: Switch-over sets flag; software clears it.
// RQ16: Low-battery flag hardware cleared, write-immune.
// RQ17: Switch-over interrupt when flag and enable set.
// RQ18: Low-battery interrupt when flag and enable set.
`timescale 1ns/1ps
`include "rtcr_regs.vh"

module rtcr_ctrl_regs (
  input  wire       clk_in,
  input  wire       rst_b_in,
  input  wire [7:0] reg_addr_in,
  input  wire       reg_wr_in,
  input  wire [7:0] reg_wdata_in,
  input  wire       reg_rd_in,
  output reg  [7:0] reg_rdata_out,
  output reg        reg_rvalid_out,
  input  wire       minute_tick_in,
  input  wire       second_tick_in,
  input  wire       watchdog_expiry_in,
  input  wire       watchdog_clear_in,
  input  wire       alarm_hit_in,
  input  wire       switchover_in,
  input  wire       low_battery_in,
  output reg        ext_clock_test_sel_out,
  output reg        temp_comp_off_out,
  output reg        divider_halt_out,
  output reg        hundredths_off_out,
  output reg        powerup_reset_bypass_en_out,
  output reg        hour12_sel_out,
  output reg  [2:0] power_mgmt_sel_out,
  output reg        switchover_stamp_out,
  output reg        tick_irq_out,
  output reg        watchdog_irq_out,
  output reg        alarm_irq_out,
  output reg        switchover_irq_out,
  output reg        low_battery_irq_out
);

  //////////////////////////////////////////////////////////////////////////
  // Supply monitor levels into the clock domain

  wire [1:0] supply_sync;
  reg        switchover_seen_r;
  wire       switchover_evt;
  wire       low_battery_lvl;

  rtcr_sync #(
    .WIDTH (2)
  ) u_supply_sync (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .async_in ({low_battery_in, switchover_in}),
    .sync_out (supply_sync)
  );

  assign low_battery_lvl = supply_sync[1];
  assign switchover_evt  = supply_sync[0] & ~switchover_seen_r;

  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      switchover_seen_r <= 1'b0;
    end else begin
      switchover_seen_r <= supply_sync[0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Write decode

  wire wr_tk;
  wire wr_aw;
  wire wr_bp;

  assign wr_tk = reg_wr_in & (reg_addr_in == `RTCR_ADDR_TK_CTRL); // RQ1
  assign wr_aw = reg_wr_in & (reg_addr_in == `RTCR_ADDR_AW_STAT); // RQ1
  assign wr_bp = reg_wr_in & (reg_addr_in == `RTCR_ADDR_BP_CTRL); // RQ1

  //////////////////////////////////////////////////////////////////////////
  // timekeeping_control

  reg [7:0] tk_ctrl_r;

  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      tk_ctrl_r <= `RTCR_RST_TK_CTRL; // RQ7
    end else if (wr_tk) begin
      tk_ctrl_r <= reg_wdata_in;
    end
  end

  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      ext_clock_test_sel_out      <= 1'b0;
      temp_comp_off_out           <= 1'b0;
      divider_halt_out            <= 1'b0;
      hundredths_off_out          <= 1'b0;
      powerup_reset_bypass_en_out <= 1'b1;
      hour12_sel_out              <= 1'b0;
    end else begin
      ext_clock_test_sel_out      <= tk_ctrl_r[`RTCR_TK_EXT_CLOCK_TEST_SEL]; // RQ3
      temp_comp_off_out           <= tk_ctrl_r[`RTCR_TK_TEMP_OFF]; // RQ4
      // Divider chain is held cleared and the clock is stopped while halted
      divider_halt_out            <= tk_ctrl_r[`RTCR_TK_HALT]; // RQ5
      // Level both stops the hundredths counter and holds it at zero
      hundredths_off_out          <= tk_ctrl_r[`RTCR_TK_HUND_OFF]; // RQ6
      powerup_reset_bypass_en_out <= tk_ctrl_r[`RTCR_TK_BYPASS_EN]; // RQ7
      hour12_sel_out              <= tk_ctrl_r[`RTCR_TK_HOUR12]; // RQ8
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // alarm_watchdog_status, plus the switch-over flag of battery_power_control

  // Software-clearable flags share one set/clear cell per entry
  localparam FLAG_TICK  = 0;
  localparam FLAG_ALARM = 1;
  localparam FLAG_SWOV  = 2;
  localparam NUM_FLAGS  = 3;

  wire                 tick_evt;
  wire [NUM_FLAGS-1:0] flag_set;
  wire [NUM_FLAGS-1:0] flag_clr;
  wire [NUM_FLAGS-1:0] flag_vec;
  wire                 tick_flag;
  wire                 alarm_hit_flag;
  wire                 switchover_flag;
  reg                  watchdog_expiry_flag_r;
  reg                  alarm_irq_en_r;

  assign tick_evt = (minute_tick_in & tk_ctrl_r[`RTCR_TK_MIN_EN])
                  | (second_tick_in & tk_ctrl_r[`RTCR_TK_SEC_EN]); // RQ9

  assign flag_set[FLAG_TICK]  = tick_evt; // RQ9
  assign flag_set[FLAG_ALARM] = alarm_hit_in; // RQ11
  assign flag_set[FLAG_SWOV]  = switchover_evt; // RQ15

  // Writing zero clears a flag; writing one leaves it as it is
  assign flag_clr[FLAG_TICK]  =
    wr_aw & ~reg_wdata_in[`RTCR_AW_TICK_F]; // RQ9
  assign flag_clr[FLAG_ALARM] =
    wr_aw & ~reg_wdata_in[`RTCR_AW_ALARM_F]; // RQ11
  assign flag_clr[FLAG_SWOV]  =
    wr_bp & ~reg_wdata_in[`RTCR_BP_SW_F]; // RQ15

  genvar fi;
  generate
    for (fi = 0; fi < NUM_FLAGS; fi = fi + 1) begin : g_flag
      reg flag_bit_r;
      // An event in the clearing cycle wins, so no event is lost
      always @(posedge clk_in) begin
        if (!rst_b_in) begin
          flag_bit_r <= 1'b0;
        end else if (flag_set[fi]) begin
          flag_bit_r <= 1'b1;
        end else if (flag_clr[fi]) begin
          flag_bit_r <= 1'b0;
        end
      end
      assign flag_vec[fi] = flag_bit_r;
    end
  endgenerate

  assign tick_flag       = flag_vec[FLAG_TICK];
  assign alarm_hit_flag  = flag_vec[FLAG_ALARM];
  assign switchover_flag = flag_vec[FLAG_SWOV];

  // Only the watchdog itself clears its flag; no write reaches it
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      watchdog_expiry_flag_r <= 1'b0;
    end else if (watchdog_expiry_in) begin
      watchdog_expiry_flag_r <= 1'b1; // RQ10
    end else if (watchdog_clear_in) begin
      watchdog_expiry_flag_r <= 1'b0; // RQ10
    end
  end

  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      alarm_irq_en_r <= 1'b0;
    end else if (wr_aw) begin
      alarm_irq_en_r <= reg_wdata_in[`RTCR_AW_ALARM_EN]; // RQ12
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // battery_power_control

  reg [2:0] power_mgmt_sel_r;
  reg       switchover_stamp_en_r;
  reg       low_battery_flag_r;
  reg       switchover_irq_en_r;
  reg       low_battery_irq_en_r;

  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      power_mgmt_sel_r      <= `RTCR_RST_PWR_SEL; // RQ13
      switchover_stamp_en_r <= 1'b0;
      switchover_irq_en_r   <= 1'b0;
      low_battery_irq_en_r  <= 1'b0;
    end else if (wr_bp) begin
      power_mgmt_sel_r      <=
        reg_wdata_in[`RTCR_BP_PWR_HI:`RTCR_BP_PWR_LO]; // RQ13
      switchover_stamp_en_r <= reg_wdata_in[`RTCR_BP_STAMP_EN]; // RQ14
      switchover_irq_en_r   <= reg_wdata_in[`RTCR_BP_SW_EN]; // RQ17
      low_battery_irq_en_r  <= reg_wdata_in[`RTCR_BP_LOWBAT_EN]; // RQ18
    end
  end

  // Follows the monitor level; writes never touch it, so a fresh
  // battery clears it without software help
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      low_battery_flag_r <= 1'b0;
    end else begin
      low_battery_flag_r <= low_battery_lvl; // RQ16
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs derived from flags and enables

  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      power_mgmt_sel_out   <= `RTCR_RST_PWR_SEL;
      switchover_stamp_out <= 1'b0;
    end else begin
      power_mgmt_sel_out   <= power_mgmt_sel_r; // RQ13
      // One pulse per switch-over edge, taken only while enabled
      switchover_stamp_out <= switchover_evt & switchover_stamp_en_r; // RQ14
    end
  end

  // Interrupt levels stay up until the flag or, where there is one, the enable behind them is cleared
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      tick_irq_out        <= 1'b0;
      watchdog_irq_out    <= 1'b0;
      alarm_irq_out       <= 1'b0;
      switchover_irq_out  <= 1'b0;
      low_battery_irq_out <= 1'b0;
    end else begin
      tick_irq_out        <= tick_flag; // RQ9
      watchdog_irq_out    <= watchdog_expiry_flag_r; // RQ10
      alarm_irq_out       <= alarm_hit_flag & alarm_irq_en_r; // RQ12
      switchover_irq_out  <= switchover_flag & switchover_irq_en_r; // RQ17
      low_battery_irq_out <= low_battery_flag_r & low_battery_irq_en_r; // RQ18
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read path

  reg [7:0] rd_mux;

  // Timestamp flag and enable registers live elsewhere and read zero here
  always @* begin
    rd_mux = 8'h00; // RQ2
    case (reg_addr_in)
      `RTCR_ADDR_TK_CTRL: begin
        rd_mux = tk_ctrl_r;
      end
      `RTCR_ADDR_AW_STAT: begin
        rd_mux[`RTCR_AW_TICK_F]   = tick_flag;
        rd_mux[`RTCR_AW_WDOG_F]   = watchdog_expiry_flag_r;
        rd_mux[`RTCR_AW_ALARM_F]  = alarm_hit_flag;
        rd_mux[`RTCR_AW_ALARM_EN] = alarm_irq_en_r;
      end
      `RTCR_ADDR_BP_CTRL: begin
        rd_mux[`RTCR_BP_PWR_HI:`RTCR_BP_PWR_LO] = power_mgmt_sel_r;
        rd_mux[`RTCR_BP_STAMP_EN]  = switchover_stamp_en_r;
        rd_mux[`RTCR_BP_SW_F]      = switchover_flag;
        rd_mux[`RTCR_BP_LOWBAT_F]  = low_battery_flag_r;
        rd_mux[`RTCR_BP_SW_EN]     = switchover_irq_en_r;
        rd_mux[`RTCR_BP_LOWBAT_EN] = low_battery_irq_en_r;
      end
      default: begin
        rd_mux = 8'h00; // RQ2
      end
    endcase
  end

  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      reg_rdata_out  <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        reg_rdata_out <= rd_mux; // RQ1
      end
    end
  end

endmodule // rtcr_ctrl_regs

/* File: design/rtcr_regs.vh */
// Register map, field positions and reset values of the RTC control bank.
// Assumes inclusion by bare name from the register bank design files.
`ifndef RTCR_REGS_VH
`define RTCR_REGS_VH

// Register addresses
`define RTCR_ADDR_TK_CTRL   8'h00
`define RTCR_ADDR_AW_STAT   8'h01
`define RTCR_ADDR_BP_CTRL   8'h02
`define RTCR_ADDR_TS_FLAGS  8'h03
`define RTCR_ADDR_TS_EN     8'h04

// timekeeping_control fields
`define RTCR_TK_EXT_CLOCK_TEST_SEL    7
`define RTCR_TK_TEMP_OFF    6
`define RTCR_TK_HALT        5
`define RTCR_TK_HUND_OFF    4
`define RTCR_TK_BYPASS_EN   3
`define RTCR_TK_HOUR12      2
`define RTCR_TK_MIN_EN      1
`define RTCR_TK_SEC_EN      0

// alarm_watchdog_status fields
`define RTCR_AW_TICK_F      7
`define RTCR_AW_WDOG_F      6
`define RTCR_AW_ALARM_F     4
`define RTCR_AW_ALARM_EN    1

// battery_power_control fields
`define RTCR_BP_PWR_HI      7
`define RTCR_BP_PWR_LO      5
`define RTCR_BP_STAMP_EN    4
`define RTCR_BP_SW_F        3
`define RTCR_BP_LOWBAT_F    2
`define RTCR_BP_SW_EN       1
`define RTCR_BP_LOWBAT_EN   0

// Reset values
`define RTCR_RST_TK_CTRL    8'h08
`define RTCR_RST_AW_STAT    8'h00
`define RTCR_RST_BP_CTRL    8'hE0
`define RTCR_RST_PWR_SEL    3'h7

// Hundredths register that the hundredths-off bit forces to zero
`define RTCR_ADDR_HUNDREDTHS 8'h06
`define RTCR_HUNDREDTHS_ZERO 8'h00

`endif

/* File: design/rtcr_sync.v */
// Two flip-flop synchroniser, one stage pair per bit.
// Assumes inputs asynchronous to clk_in; outputs are clk_in aligned.
`timescale 1ns/1ps

module rtcr_sync #(
  parameter WIDTH = 2
) (
  input  wire             clk_in,
  input  wire             rst_b_in,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta_r;
      reg sync_r;
      always @(posedge clk_in) begin
        if (!rst_b_in) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
        end else begin
          meta_r <= async_in[i];
          sync_r <= meta_r;
        end
      end
      assign sync_out[i] = sync_r;
    end
  endgenerate

endmodule // rtcr_sync

/* File: tb/rtcr_ctrl_regs_properties.sv */
// Port checker for the RTC control and status register bank.
// Assumes binding into rtcr_ctrl_regs; one clock, synchronous reset.
`timescale 1ns/1ps
module rtcr_ctrl_regs_chk (
  input wire       clk_in, rst_b_in, reg_wr_in, reg_rd_in, reg_rvalid_out,
  input wire       divider_halt_out, watchdog_expiry_in, watchdog_clear_in,
  input wire       watchdog_irq_out, minute_tick_in, second_tick_in,
  input wire       tick_irq_out, switchover_in, switchover_stamp_out,
  input wire [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  AST_READ_ANSWERED:
    assert property (reg_rd_in |=> reg_rvalid_out) else $error("no answer");
  AST_VALID_CAUSED:
    assert property (reg_rvalid_out |-> $past(reg_rd_in))
    else $error("stray valid");
  AST_HIGH_ADDR_ZERO:
    assert property (reg_rd_in && reg_addr_in > 8'h02 |=>
      reg_rdata_out == 8'h00) else $error("unmapped read not zero");
  AST_UNUSED_ZERO:
    assert property (reg_rd_in && reg_addr_in == 8'h01 |=>
      (reg_rdata_out & 8'h2D) == 8'h00) else $error("unused bit set");
  AST_HALT_FOLLOWS:
    assert property (reg_wr_in && reg_addr_in == 8'h00 ##1
      !(reg_wr_in && reg_addr_in == 8'h00) |=>
      divider_halt_out == $past(reg_wdata_in[5], 2)) else $error("halt");
  AST_WDOG_HOLDS:
    assert property (watchdog_irq_out && !watchdog_clear_in &&
      !$past(watchdog_clear_in) |=> watchdog_irq_out) else $error("wdog lost");
  AST_WDOG_SETS:
    assert property (watchdog_expiry_in && !watchdog_clear_in ##1
      !watchdog_clear_in |=> watchdog_irq_out) else $error("wdog not set");
  AST_TICK_CAUSE:
    assert property ($rose(tick_irq_out) |-> $past(minute_tick_in, 2) ||
      $past(second_tick_in, 2)) else $error("tick without event");
  AST_STAMP_CAUSE:
    assert property (switchover_stamp_out |-> $past(switchover_in, 3) &&
      !$past(switchover_in, 4)) else $error("stamp without switch-over");
endmodule // rtcr_ctrl_regs_chk

bind rtcr_ctrl_regs rtcr_ctrl_regs_chk i_chk (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rvalid_out(reg_rvalid_out),
  .divider_halt_out(divider_halt_out),
  .watchdog_expiry_in(watchdog_expiry_in),
  .watchdog_clear_in(watchdog_clear_in),
  .watchdog_irq_out(watchdog_irq_out), .minute_tick_in(minute_tick_in),
  .second_tick_in(second_tick_in), .tick_irq_out(tick_irq_out),
  .switchover_in(switchover_in),
  .switchover_stamp_out(switchover_stamp_out), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out)
);

/* File: tb/tb_top.sv */
// Self-checking bench for the RTC control and status register bank.
// Drives all inputs at the falling edge of a 10 MHz clock.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks = checks + 1; if ((g) !== (e)) begin \
  errors = errors + 1; $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_top;
  reg        clk_in = 0, rst_b_in = 0, wr = 0, rd = 0, mt = 0, st = 0;
  reg        we = 0, wc = 0, ah = 0, so = 0, lb = 0;
  reg  [7:0] ad = 8'h00, wd = 8'h00;
  wire [7:0] rdat;
  wire [2:0] pwr;
  wire       rv, tst, tc, hlt, hun, byp, h12, stp, ti, wi, ai, si, li;
  integer    errors = 0, checks = 0, n;
  rtcr_ctrl_regs i_dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .reg_addr_in(ad), .reg_wr_in(wr), .reg_wdata_in(wd), .reg_rd_in(rd),
    .reg_rdata_out(rdat), .reg_rvalid_out(rv), .minute_tick_in(mt),
    .second_tick_in(st), .watchdog_expiry_in(we), .watchdog_clear_in(wc),
    .alarm_hit_in(ah), .switchover_in(so), .low_battery_in(lb),
    .ext_clock_test_sel_out(tst), .temp_comp_off_out(tc),
    .divider_halt_out(hlt), .hundredths_off_out(hun),
    .powerup_reset_bypass_en_out(byp), .hour12_sel_out(h12),
    .power_mgmt_sel_out(pwr), .switchover_stamp_out(stp),
    .tick_irq_out(ti), .watchdog_irq_out(wi), .alarm_irq_out(ai),
    .switchover_irq_out(si), .low_battery_irq_out(li));
  initial forever #50 clk_in = ~clk_in;
  //////////////////////////////////////////////////////////////////////////
  task cyc(input integer k); repeat (k) @(negedge clk_in); endtask
  task w(input [7:0] a, d); begin
    cyc(1); ad = a; wd = d; wr = 1; cyc(1); wr = 0; end endtask
  task r(input [7:0] a, e); begin
    cyc(1); ad = a; rd = 1; cyc(1); rd = 0;
    `CHK("rvalid", 1'b1, rv)
    `CHK("rdata", e, rdat) end endtask
  task t_reset; begin
    r(8'h00, 8'h08);
    r(8'h01, 8'h00);
    r(8'h02, 8'hE0);
    `CHK("pwr", 3'h7, pwr)
    `CHK("bypass", 1'b1, byp) end endtask
  task t_ctrl; begin
    w(8'h00, 8'hA8); cyc(1);
    `CHK("ctrl", 6'h2A, {tst, tc, hlt, hun, byp, h12})
    r(8'h00, 8'hA8);
    w(8'h00, 8'h55); cyc(1);
    `CHK("ctrl", 6'h15, {tst, tc, hlt, hun, byp, h12}) end endtask
  task t_status; begin
    w(8'h01, 8'hFF); r(8'h01, 8'h02);
    w(8'h02, 8'hFF); r(8'h02, 8'hF3);
    w(8'h03, 8'hFF); r(8'h03, 8'h00);
    r(8'h40, 8'h00); end endtask
  task t_tick; begin
    cyc(1); mt = 1; cyc(1); mt = 0; cyc(1); `CHK("tick", 1'b0, ti)
    st = 1; cyc(1); st = 0; cyc(1); `CHK("tick", 1'b1, ti)
    r(8'h01, 8'h82); w(8'h01, 8'h02); cyc(1);
    `CHK("tick", 1'b0, ti)
    w(8'h00, 8'h56); st = 1; cyc(1); st = 0; cyc(1);
    `CHK("tick", 1'b0, ti)
    mt = 1; cyc(1); mt = 0; cyc(1); `CHK("tick", 1'b1, ti)
    w(8'h01, 8'h02); end endtask
  task t_alarm; begin
    ah = 1; cyc(1); ah = 0; cyc(1); `CHK("alarm", 1'b1, ai)
    r(8'h01, 8'h12); w(8'h01, 8'h00); cyc(1);
    `CHK("alarm", 1'b0, ai)
    ah = 1; cyc(1); ah = 0; cyc(1); `CHK("alarm", 1'b0, ai)
    r(8'h01, 8'h10); w(8'h01, 8'h00); end endtask
  task t_wdog; begin
    we = 1; cyc(1); we = 0; cyc(1); `CHK("wdog", 1'b1, wi)
    w(8'h01, 8'h00); r(8'h01, 8'h40);
    wc = 1; cyc(1); wc = 0; cyc(1); `CHK("wdog", 1'b0, wi) end endtask
  task t_batt; begin
    so = 1; n = 0;
    repeat (6) begin cyc(1); n = n + stp; end
    `CHK("stamps", 1, n)
    `CHK("swirq", 1'b1, si)
    r(8'h02, 8'hFB); w(8'h02, 8'hF3); cyc(1);
    `CHK("swirq", 1'b0, si)
    lb = 1; cyc(6); `CHK("lowirq", 1'b1, li)
    w(8'h02, 8'hF3); r(8'h02, 8'hF7);
    lb = 0; cyc(6); r(8'h02, 8'hF3);
    w(8'h02, 8'h53); r(8'h02, 8'h53);
    `CHK("pwr", 3'h2, pwr) end endtask
  task close_out; begin
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish; end endtask
  initial begin
    cyc(4); rst_b_in = 1;
    t_reset; t_ctrl; t_status; t_tick; t_alarm; t_wdog; t_batt;
    close_out;
  end
  initial begin #200000; errors = errors + 1; close_out; end
endmodule // tb_top
